// file: dcia_daisy_chain_interrupt_ack.sv
// Interrupt priority, acknowledge and return detection for a four channel timer
`timescale 1ns/1ns
`default_nettype none
`include "dcia_consts.svh"
module dcia_daisy_chain_interrupt_ack
  import dcia_pkg::*;
#(
  parameter int CHANNELS = `DCIA_CHANNELS
)(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Processor bus
  input wire logic machineCycleOne_n,
  input wire logic ioRequestStrobe_n,
  input wire logic read_n,
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic dataOutEn,
  output logic waitReq_n,
  output logic intReq_n,
  // Chain
  input wire logic chainEnableIn,
  output logic chainEnableOut,
  // Channel side
  input wire logic [CHANNELS-1:0] chanRequest,
  input wire logic [4:0] vectorBase
);

  dcia_state_t state_reg;
  dcia_state_t state_next;

  // Lowest numbered requester wins
  function automatic logic [3:0] pickFirst(input logic [3:0] req);
    logic [3:0] r;
    r = 4'h0;
    if (req[0]) r = 4'h1;
    else if (req[1]) r = 4'h2;
    else if (req[2]) r = 4'h4;
    else if (req[3]) r = 4'h8;
    return r;
  endfunction : pickFirst

  // Mask of channels above the highest in service
  function automatic logic [3:0] aboveMask(input logic [3:0] svc);
    logic [3:0] m;
    m = 4'hF;
    if (svc[0]) m = 4'h0;
    else if (svc[1]) m = 4'h1;
    else if (svc[2]) m = 4'h3;
    else if (svc[3]) m = 4'h7;
    return m;
  endfunction : aboveMask

  function automatic logic [1:0] codeOf(input logic [3:0] oneHot);
    logic [1:0] c;
    c = 2'h0;
    if (oneHot[1]) c = 2'h1;
    else if (oneHot[2]) c = 2'h2;
    else if (oneHot[3]) c = 2'h3;
    return c;
  endfunction : codeOf

  logic ackCycle;
  logic opFetch;
  logic [3:0] eligible;
  logic [3:0] winner;
  logic [3:0] lowestSvc;

  assign ackCycle = !machineCycleOne_n && !ioRequestStrobe_n;
  assign opFetch = !machineCycleOne_n && !read_n && ioRequestStrobe_n;
  assign eligible = state_reg.pending & aboveMask(state_reg.inService);
  assign winner = pickFirst(eligible);
  assign lowestSvc = pickFirst(state_reg.inService);

  always_comb
  begin
    state_next = state_reg;
    // Capture new requests unless frozen by machine cycle one
    if (machineCycleOne_n)
    begin
      state_next.pending = state_reg.pending | chanRequest[3:0];
    end
    // Resolve winner ahead of I/O request
    if (!machineCycleOne_n && ioRequestStrobe_n && state_reg.phase == DCIA_IDLE)
    begin
      state_next.grantOneHot = winner;
    end
    case (state_reg.phase)
      DCIA_IDLE:
      begin
        if (ackCycle && chainEnableIn && state_reg.grantOneHot != 4'h0)
        begin
          state_next.phase = DCIA_ACK_WAIT;
          state_next.waitCount = 2'h0;
          state_next.dataOut = {vectorBase, codeOf(state_reg.grantOneHot), 1'b0};
          state_next.dataOutEn = 1'b1;
        end
      end
      DCIA_ACK_WAIT:
      begin
        state_next.waitCount = state_reg.waitCount + 2'h1;
        if (state_reg.waitCount == 2'(`DCIA_WAIT_STATES - 1))
        begin
          state_next.phase = DCIA_ACK_DRIVE;
        end
      end
      DCIA_ACK_DRIVE:
      begin
        if (!ackCycle)
        begin
          state_next.phase = DCIA_IDLE;
          state_next.dataOutEn = 1'b0;
          state_next.pending = (state_reg.pending & ~state_reg.grantOneHot)
                               | (machineCycleOne_n ? chanRequest[3:0] : 4'h0);
          state_next.inService = state_reg.inService | state_reg.grantOneHot;
          state_next.grantOneHot = 4'h0;
        end
      end
      default:
      begin
        state_next.phase = DCIA_IDLE;
      end
    endcase
    // Return sequence decode on each new opcode fetch
    state_next.fetchPrev = opFetch;
    if (opFetch && !state_reg.fetchPrev)
    begin
      if (state_reg.prefixSeen && dataIn == `DCIA_OP_RETURN && chainEnableIn)
      begin
        state_next.inService = (state_reg.inService & ~lowestSvc)
                               | (state_next.inService & ~state_reg.inService);
      end
      state_next.prefixSeen = dataIn == `DCIA_OP_PREFIX;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= '{phase: DCIA_IDLE, default: '0};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign dataOut = state_reg.dataOut;
  assign dataOutEn = state_reg.dataOutEn;
  assign waitReq_n = !(state_reg.phase == DCIA_ACK_WAIT || (ackCycle && state_reg.phase == DCIA_IDLE
                      && chainEnableIn && state_reg.grantOneHot != 4'h0));
  assign intReq_n = !(eligible != 4'h0 && chainEnableIn);
  // Prefix byte opens the chain below for the second byte
  assign chainEnableOut = chainEnableIn && state_reg.pending == 4'h0
                          && (state_reg.inService == 4'h0 || state_reg.prefixSeen);

  chain_gate_a: assert property (@(posedge clock) disable iff (!rstn)
    !chainEnableIn |-> !chainEnableOut) else $error("chain out high with chain in low");
  wait_count_a: assert property (@(posedge clock) disable iff (!rstn)
    state_reg.phase == DCIA_IDLE ##1 state_reg.phase == DCIA_ACK_WAIT
    |-> state_reg.phase == DCIA_ACK_WAIT [*2] ##1 state_reg.phase == DCIA_ACK_DRIVE)
    else $error("wait states not two");
  vector_drive_a: assert property (@(posedge clock) disable iff (!rstn)
    state_reg.phase == DCIA_ACK_DRIVE && ackCycle |=> dataOutEn) else $error("vector dropped early");
  vector_code_a: assert property (@(posedge clock) disable iff (!rstn)
    dataOutEn |-> dataOut[2:1] == codeOf(state_reg.grantOneHot) && !dataOut[0])
    else $error("vector code mismatch");
  freeze_req_a: assert property (@(posedge clock) disable iff (!rstn)
    !machineCycleOne_n && state_reg.phase == DCIA_IDLE |=> state_reg.pending == $past(state_reg.pending))
    else $error("requests changed under machine cycle one");
  priority_win_a: assert property (@(posedge clock) disable iff (!rstn)
    $rose(dataOutEn) |-> !$past(state_reg.pending[0]) || state_reg.grantOneHot[0]
    || $past(state_reg.inService[0])) else $error("channel 0 lost priority");
  service_hold_a: assert property (@(posedge clock) disable iff (!rstn)
    state_reg.inService != 4'h0 && !state_reg.prefixSeen |-> !chainEnableOut)
    else $error("chain out high during service");
  return_clear_a: assert property (@(posedge clock) disable iff (!rstn)
    opFetch && !state_reg.fetchPrev && state_reg.prefixSeen && dataIn == `DCIA_OP_RETURN
    && chainEnableIn && state_reg.inService != 4'h0
    |=> $countones(state_reg.inService) < $countones($past(state_reg.inService)))
    else $error("return did not clear service");

  // Further acknowledge, request and return checks
  grant_latch_a: assert property (@(posedge clock) disable iff (!rstn)
    !machineCycleOne_n && ioRequestStrobe_n && state_reg.phase == DCIA_IDLE
    |=> state_reg.grantOneHot == $past(winner))
    else $error("winner not latched before request");
  no_chain_ack_a: assert property (@(posedge clock) disable iff (!rstn)
    state_reg.phase == DCIA_IDLE && !chainEnableIn |=> !dataOutEn)
    else $error("vector driven without chain enable");
  vector_base_a: assert property (@(posedge clock) disable iff (!rstn)
    dataOutEn |-> dataOut[7:3] == vectorBase)
    else $error("vector upper bits changed");
  nest_order_a: assert property (@(posedge clock) disable iff (!rstn)
    $rose(dataOutEn) && state_reg.inService != 4'h0
    |-> state_reg.grantOneHot < pickFirst(state_reg.inService))
    else $error("lower priority acknowledged during service");
  first_int_a: assert property (@(posedge clock) disable iff (!rstn)
    chainEnableIn && state_reg.pending[0] && !state_reg.inService[0] |-> !intReq_n)
    else $error("channel 0 request not signalled");
  service_set_a: assert property (@(posedge clock) disable iff (!rstn)
    state_reg.phase == DCIA_ACK_DRIVE && !ackCycle
    |=> (state_reg.inService & $past(state_reg.grantOneHot)) != 4'h0)
    else $error("acknowledged channel not in service");
  prefix_need_a: assert property (@(posedge clock) disable iff (!rstn)
    opFetch && !state_reg.prefixSeen && state_reg.phase == DCIA_IDLE
    |=> state_reg.inService == $past(state_reg.inService))
    else $error("service cleared without prefix byte");
  prefix_open_a: assert property (@(posedge clock) disable iff (!rstn)
    state_reg.prefixSeen && chainEnableIn && state_reg.pending == 4'h0 |-> chainEnableOut)
    else $error("chain not opened after prefix byte");

endmodule : dcia_daisy_chain_interrupt_ack
`default_nettype wire

// file: dcia_consts.svh
// Constants for the daisy chain interrupt acknowledge block
`ifndef DCIA_CONSTS_SVH
`define DCIA_CONSTS_SVH
`define DCIA_CHANNELS 4
`define DCIA_OP_PREFIX 8'hED
`define DCIA_OP_RETURN 8'h4D
`define DCIA_WAIT_STATES 2
`define DCIA_CODE_LSB 1
`define DCIA_CODE_MSB 2
`endif

// file: dcia_pkg.sv
// Types for the daisy chain interrupt acknowledge block
`default_nettype none
package dcia_pkg;
  typedef enum logic [1:0] {
    DCIA_IDLE,
    DCIA_ACK_WAIT,
    DCIA_ACK_DRIVE
  } dcia_phase_t;
  typedef struct packed {
    dcia_phase_t phase;
    logic [3:0] pending;
    logic [3:0] inService;
    logic [3:0] grantOneHot;
    logic [1:0] waitCount;
    logic prefixSeen;
    logic fetchPrev;
    logic [7:0] dataOut;
    logic dataOutEn;
  } dcia_state_t;
endpackage : dcia_pkg
`default_nettype wire

// file: dcia_cpu_model.sv
// Processor side model for acknowledge and opcode fetch cycles
`timescale 1ns/1ns
`default_nettype none
module dcia_cpu_model (
  // Clock
  input wire logic clock,
  // Bus to block
  output logic machineCycleOne_n,
  output logic ioRequestStrobe_n,
  output logic rdN,
  output logic [7:0] bus,
  // Answers from block
  input wire logic [7:0] dataOut,
  input wire logic dataOutEn,
  input wire logic waitReq_n
);
  initial {machineCycleOne_n, ioRequestStrobe_n, rdN, bus} = {3'b111, 8'hA5};
  task automatic ack(input int extra, output logic [7:0] vec, output int waits);
    @(negedge clock) machineCycleOne_n = 1'b0;
    repeat (2) @(negedge clock);
    ioRequestStrobe_n = 1'b0;
    waits = 0;
    @(negedge clock);
    while (waitReq_n === 1'b0 && waits < 20)
    begin
      waits++;
      @(negedge clock);
    end
    repeat (extra) @(negedge clock);
    vec = dataOutEn === 1'b1 ? dataOut : 8'h00;
    {machineCycleOne_n, ioRequestStrobe_n, bus} = {2'b11, ~bus};
  endtask : ack
  task automatic fetch(input logic [7:0] op);
    @(negedge clock) {machineCycleOne_n, rdN, bus} = {2'b00, op};
    @(negedge clock) {machineCycleOne_n, rdN, bus} = {2'b11, ~op};
  endtask : fetch
endmodule : dcia_cpu_model
`default_nettype wire

// file: tb_daisy_chain_interrupt_ack.sv
// Self-checking bench for the daisy chain interrupt acknowledge block
`timescale 1ns/1ns
`default_nettype none
`include "dcia_consts.svh"
module tb_daisy_chain_interrupt_ack;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic chainEnableIn = 1'b1;
  logic [3:0] chanRequest = 4'h0;
  logic [4:0] vectorBase = 5'h15;
  wire logic machineCycleOne_n, ioRequestStrobe_n, rdN, dataOutEn, waitReq_n, intReq_n, chainEnableOut;
  wire logic [7:0] bus, dataOut;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [7:0] vec;
  int waits;
  initial forever #10 clock = ~clock;
  dcia_daisy_chain_interrupt_ack DUT (.clock(clock), .rstn(rstn), .machineCycleOne_n(machineCycleOne_n),
    .ioRequestStrobe_n(ioRequestStrobe_n), .read_n(rdN), .dataIn(bus), .dataOut(dataOut), .dataOutEn(dataOutEn),
    .waitReq_n(waitReq_n), .intReq_n(intReq_n), .chainEnableIn(chainEnableIn),
    .chainEnableOut(chainEnableOut), .chanRequest(chanRequest), .vectorBase(vectorBase));
  dcia_cpu_model cpu (.clock(clock), .machineCycleOne_n(machineCycleOne_n),
    .ioRequestStrobe_n(ioRequestStrobe_n), .rdN(rdN), .bus(bus),
    .dataOut(dataOut), .dataOutEn(dataOutEn), .waitReq_n(waitReq_n));
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      end_of_test();
    end
  end
  function automatic logic [7:0] vecOf(input logic [1:0] ch);
    return {vectorBase, ch, 1'b0};
  endfunction : vecOf
  task automatic raise(input logic [3:0] mask);
    @(negedge clock) chanRequest = mask;
    @(negedge clock) chanRequest = 4'h0;
  endtask : raise
  task automatic ackCheck(input int extra, input logic [1:0] ch);
    cpu.ack(extra, vec, waits);
    check("vector", vec, vecOf(ch));
    check("waits", waits[7:0], 8'(`DCIA_WAIT_STATES));
    @(negedge clock);
    check("ceo", {7'h0, chainEnableOut}, 8'h00);
  endtask : ackCheck
  task automatic ret();
    cpu.fetch(`DCIA_OP_PREFIX);
    cpu.fetch(`DCIA_OP_RETURN);
  endtask : ret
  task automatic testSingle();
    check("ceoIdle", {7'h0, chainEnableOut}, 8'h01);
    raise(4'h2);
    check("int", {7'h0, intReq_n}, 8'h00);
    ackCheck(3, 2'h1);
    ret();
    check("ceoRet", {7'h0, chainEnableOut}, 8'h01);
  endtask : testSingle
  task automatic testNest();
    raise(4'h4);
    ackCheck(0, 2'h2);
    raise(4'h2);
    check("intHi", {7'h0, intReq_n}, 8'h00);
    ackCheck(2, 2'h1);
    raise(4'h8);
    check("intLo", {7'h0, intReq_n}, 8'h01);
    ret();
    check("intMask", {7'h0, intReq_n}, 8'h01);
    ret();
    check("intPend", {7'h0, intReq_n}, 8'h00);
    ackCheck(0, 2'h3);
    ret();
  endtask : testNest
  task automatic testPriority();
    raise(4'h9);
    ackCheck(1, 2'h0);
    ret();
    ackCheck(0, 2'h3);
    ret();
  endtask : testPriority
  task automatic testChain();
    @(negedge clock) chainEnableIn = 1'b0;
    raise(4'h4);
    check("ceoOff", {7'h0, chainEnableOut}, 8'h00);
    cpu.ack(0, vec, waits);
    check("noVec", vec, 8'h00);
    @(negedge clock) chainEnableIn = 1'b1;
    ackCheck(0, 2'h2);
    ret();
  endtask : testChain
  initial
  begin
    repeat (10) @(negedge clock);
    rstn = 1'b1;
    @(negedge clock);
    testSingle();
    testNest();
    testPriority();
    testChain();
    end_of_test();
  end
endmodule : tb_daisy_chain_interrupt_ack
`default_nettype wire
